// ===== rtl/dmacr_regs_top.sv
/*
 * eight-channel dma address and count register set with the shared
 * collision status, block interrupts and the per-channel engines.
 * assumes one clock, strobes from same-clock logic, software bus with
 * read data one cycle after the read strobe.
 */
`timescale 1ns/100ps
`include "dmacr_defs.svh"
module dmacr_regs_top (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset,
    // software register port
    input  wire logic [7:0]             i_addr,
    input  wire logic [15:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [15:0]            o_rdata,
    // transfer requests, one pulse per item
    input  wire logic [7:0]             i_req,
    // software writes to peripheral registers and buffer ram
    input  wire logic                   i_sw_periph_wr,
    input  wire logic [15:0]            i_sw_periph_addr,
    input  wire logic                   i_sw_ram_wr,
    input  wire logic [15:0]            i_sw_ram_addr,
    // transfers issued by each channel
    output dmacr_pkg::dmacr_xfer_s      o_xfer [8],
    output logic                        o_irq
);
    import dmacr_pkg::*;

    // per-channel register storage
    logic [15:0]  pri_q  [8];  // primary buffer start
    logic [15:0]  sec_q  [8];  // secondary buffer start
    logic [15:0]  pad_q  [8];  // peripheral register address
    logic [9:0]   cnt_q  [8];  // transfer count, low bits only
    dmacr_ctrl_s  ctrl_q [8];  // control word

    // shared state
    logic [7:0]   istat_q;      // sticky block/half events
    logic [7:0]   imask_q;      // interrupt enables
    logic [15:0]  coll_w;       // collision flags
    logic [7:0]   pp_sel_w;     // buffer in use per channel
    logic [7:0]   evt_w;        // event pulses from engines
    logic [7:0]   stop_w;       // one-shot completion pulses
    logic [7:0]   pcoll_w;      // peripheral collisions this cycle
    logic [7:0]   rcoll_w;      // ram collisions this cycle
    logic [15:0]  coll_clr_w;   // write-one-to-clear for flags
    logic [15:0]  rdata_d;      // read mux result

    // decode: channel window, channel index and register index
    logic         chan_hit_w;
    logic [2:0]   chan_w;
    logic [2:0]   reg_w;

    assign chan_hit_w = (i_addr < `DMACR_CHAN_TOP);
    assign chan_w     = i_addr[5:3];
    assign reg_w      = i_addr[2:0];

    // per-channel registers, engines and collision detectors
    genvar gc;
    generate
        for (gc = 0; gc < 8; gc++) begin : g_chan
            logic wr_ch_w;  // write aimed at this channel

            assign wr_ch_w = i_wr && chan_hit_w && (chan_w == 3'(gc));

            // address registers; a write while running is the writer's
            // risk, the engine simply picks up the new value
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    pri_q[gc] <= `DMACR_RST16;
                    sec_q[gc] <= `DMACR_RST16;
                    pad_q[gc] <= `DMACR_RST16;
                end else if (wr_ch_w) begin
                    if (reg_w == `DMACR_REG_PRI) begin
                        pri_q[gc] <= i_wdata;
                    end else if (reg_w == `DMACR_REG_SEC) begin
                        sec_q[gc] <= i_wdata;
                    end else if (reg_w == `DMACR_REG_PAD) begin
                        pad_q[gc] <= i_wdata;
                    end
                end
            end

            // count: only the low ten bits are stored
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    cnt_q[gc] <= `DMACR_RST_CNT;
                end else if (wr_ch_w && (reg_w == `DMACR_REG_CNT)) begin
                    cnt_q[gc] <= i_wdata[`DMACR_CNT_MSB:0];
                end
            end

            // control word; one-shot end drops channel_on unless
            // software writes the word in that same cycle
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    ctrl_q[gc] <= '0;
                end else if (wr_ch_w && (reg_w == `DMACR_REG_CTRL)) begin
                    ctrl_q[gc] <= dmacr_ctrl_s'(i_wdata & `DMACR_CTRL_MASK);
                end else if (stop_w[gc]) begin
                    ctrl_q[gc].channel_on <= 1'b0;
                end
            end

            dmacr_chan u_chan (
                .i_ref_clk (i_ref_clk),
                .i_reset   (i_reset),
                .i_ctrl    (ctrl_q[gc]),
                .i_pri     (pri_q[gc]),
                .i_sec     (sec_q[gc]),
                .i_pad     (pad_q[gc]),
                .i_cnt     (cnt_q[gc]),
                .i_req     (i_req[gc]),
                .o_xfer    (o_xfer[gc]),
                .o_evt     (evt_w[gc]),
                .o_stop    (stop_w[gc]),
                .o_pp_sel  (pp_sel_w[gc])
            );

            // collision: software and channel write the same target
            // in the same cycle; compared against the issued transfer
            assign pcoll_w[gc] = i_sw_periph_wr && o_xfer[gc].valid && o_xfer[gc].dir
                                 && (o_xfer[gc].periph_addr == i_sw_periph_addr);
            assign rcoll_w[gc] = i_sw_ram_wr && o_xfer[gc].valid && !o_xfer[gc].dir
                                 && (o_xfer[gc].ram_addr == i_sw_ram_addr);
        end
    endgenerate

    // collision flags are write-one-to-clear only
    assign coll_clr_w = (i_wr && (i_addr == `DMACR_ADDR_COLL)) ? i_wdata : `DMACR_RST16;

    dmacr_collide u_collide (
        .i_ref_clk    (i_ref_clk),
        .i_reset      (i_reset),
        .i_periph_set (pcoll_w),
        .i_ram_set    (rcoll_w),
        .i_clear      (coll_clr_w),
        .o_status     (coll_w)
    );

    // interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            istat_q <= `DMACR_RST8;
        end else if (i_wr && (i_addr == `DMACR_ADDR_ISTAT)) begin
            istat_q <= evt_w | (istat_q & ~i_wdata[7:0]);
        end else begin
            istat_q <= evt_w | istat_q;
        end
    end

    // interrupt mask
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            imask_q <= `DMACR_RST8;
        end else if (i_wr && (i_addr == `DMACR_ADDR_IMASK)) begin
            imask_q <= i_wdata[7:0];
        end
    end

    // level interrupt, high while any unmasked event is pending
    assign o_irq = |(istat_q & imask_q);

    // read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_d = `DMACR_RST16;
        if (chan_hit_w) begin
            if (reg_w == `DMACR_REG_PRI) begin
                rdata_d = pri_q[chan_w];
            end else if (reg_w == `DMACR_REG_SEC) begin
                rdata_d = sec_q[chan_w];
            end else if (reg_w == `DMACR_REG_PAD) begin
                rdata_d = pad_q[chan_w];
            end else if (reg_w == `DMACR_REG_CNT) begin
                rdata_d = {6'h00, cnt_q[chan_w]};
            end else if (reg_w == `DMACR_REG_CTRL) begin
                rdata_d = 16'(ctrl_q[chan_w]) & `DMACR_CTRL_MASK;
            end
        end else if (i_addr == `DMACR_ADDR_COLL) begin
            rdata_d = coll_w;
        end else if (i_addr == `DMACR_ADDR_ISTAT) begin
            rdata_d = {8'h00, istat_q};
        end else if (i_addr == `DMACR_ADDR_IMASK) begin
            rdata_d = {8'h00, imask_q};
        end else if (i_addr == `DMACR_ADDR_PPSTAT) begin
            rdata_d = {8'h00, pp_sel_w};
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= `DMACR_RST16;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= `DMACR_RST16;
        end
    end

endmodule : dmacr_regs_top

// ===== rtl/dmacr_defs.svh
/*
 * constants for the dma channel address/count register block:
 * register offsets, control field positions, reset values, steps.
 * assumes it is included by bare name from the rtl files only.
 */
`ifndef DMACR_DEFS_SVH
`define DMACR_DEFS_SVH

// per-channel register index, address bits [2:0]
`define DMACR_REG_PRI       3'h0
`define DMACR_REG_SEC       3'h1
`define DMACR_REG_PAD       3'h2
`define DMACR_REG_CNT       3'h3
`define DMACR_REG_CTRL      3'h4
// channel registers sit below this address, channel in bits [5:3]
`define DMACR_CHAN_TOP      8'h40
// shared registers
`define DMACR_ADDR_COLL     8'h40
`define DMACR_ADDR_ISTAT    8'h41
`define DMACR_ADDR_IMASK    8'h42
`define DMACR_ADDR_PPSTAT   8'h43
// reset values
`define DMACR_RST16         16'h0000
`define DMACR_RST8          8'h00
`define DMACR_RST_CNT       10'h000
// count field is bits 9:0
`define DMACR_CNT_MSB       9
// writable bits of the control word
`define DMACR_CTRL_MASK     16'hf033
// addressing_select codes
`define DMACR_AM_POSTINC    2'b00
`define DMACR_AM_FIXED      2'b01
// buffer address step per transfer
`define DMACR_STEP_BYTE     16'h0001
`define DMACR_STEP_WORD     16'h0002

`endif

// ===== rtl/dmacr_pkg.sv
/*
 * types shared by the dma channel register block files.
 * assumes dmacr_defs.svh is available for the numeric constants.
 */
package dmacr_pkg;

    // channel control word, laid out as its 16-bit register image
    typedef struct packed {
        logic       channel_on;   // bit 15
        logic       byte_size;    // bit 14, 1 = byte
        logic       dir;          // bit 13, 1 = ram to peripheral
        logic       half;         // bit 12, interrupt at half block
        logic [5:0] rsvd_hi;      // bits 11:6, read zero
        logic [1:0] addressing_select; // bits 5:4
        logic [1:0] rsvd_lo;      // bits 3:2, read zero
        logic [1:0] mode;         // bit 1 ping-pong, bit 0 one-shot
    } dmacr_ctrl_s;

    // one transfer issued by a channel
    typedef struct packed {
        logic        valid;
        logic        dir;
        logic        byte_size;
        logic [15:0] ram_addr;
        logic [15:0] periph_addr;
    } dmacr_xfer_s;

    // channel engine states
    typedef enum logic [1:0] {
        DMACR_ST_IDLE = 2'b01,
        DMACR_ST_RUN  = 2'b10
    } dmacr_state_e;

endpackage : dmacr_pkg

// ===== rtl/dmacr_collide.sv
/*
 * sticky collision flags, one per channel for peripheral and ram.
 * assumes set and clear strobes are on i_ref_clk, one cycle each.
 */
`timescale 1ns/100ps
`include "dmacr_defs.svh"
module dmacr_collide (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_periph_set,  // per channel collision seen
    input  wire logic [7:0]  i_ram_set,
    input  wire logic [15:0] i_clear,       // write-one-to-clear image
    output logic      [15:0] o_status       // periph in 15:8, ram in 7:0
);
    import dmacr_pkg::*;

    logic [15:0] set_w;  // set image aligned with the status layout

    assign set_w = {i_periph_set, i_ram_set};

    // one flop per flag; a set in the clear cycle wins
    genvar gb;
    generate
        for (gb = 0; gb < 16; gb++) begin : g_flag
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    o_status[gb] <= 1'b0;
                end else begin
                    // software only clears; hardware only sets
                    o_status[gb] <= set_w[gb] | (o_status[gb] & ~i_clear[gb]);
                end
            end
        end
    endgenerate

endmodule : dmacr_collide

// ===== rtl/dmacr_chan.sv
/*
 * one channel transfer engine: walks the buffer address, counts the
 * block, alternates ping-pong buffers, flags block and half events.
 * assumes requests are one-cycle pulses on i_ref_clk from logic.
 */
`timescale 1ns/100ps
`include "dmacr_defs.svh"
module dmacr_chan (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_reset,
    input  wire dmacr_pkg::dmacr_ctrl_s    i_ctrl,
    input  wire logic [15:0]               i_pri,
    input  wire logic [15:0]               i_sec,
    input  wire logic [15:0]               i_pad,
    input  wire logic [9:0]                i_cnt,
    input  wire logic                      i_req,
    output dmacr_pkg::dmacr_xfer_s         o_xfer,
    output logic                           o_evt,   // interrupt event pulse
    output logic                           o_stop,  // one-shot finished
    output logic                           o_pp_sel // 1 = secondary buffer
);
    import dmacr_pkg::*;

    dmacr_state_e state_q;
    logic [9:0]   idx_q;   // transfers done in this block
    logic [15:0]  addr_q;  // current buffer address
    logic [15:0]  step_w;
    logic         last_w;
    logic         half_w;
    logic         pp_on_w;
    logic         oneshot_w;

    assign step_w    = i_ctrl.byte_size ? `DMACR_STEP_BYTE : `DMACR_STEP_WORD;
    assign last_w    = (idx_q == i_cnt);  // count plus one items
    assign half_w    = (idx_q == (i_cnt >> 1));
    assign pp_on_w   = i_ctrl.mode[1];
    assign oneshot_w = i_ctrl.mode[0];

    // state, address and count walk
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q  <= DMACR_ST_IDLE;
            idx_q    <= `DMACR_RST_CNT;
            addr_q   <= `DMACR_RST16;
            o_pp_sel <= 1'b0;
            o_stop   <= 1'b0;
        end else begin
            o_stop <= 1'b0;
            case (state_q)
                DMACR_ST_IDLE: begin
                    // the stop pulse marks the cycle in which channel_on is
                    // still seen high; without it a one-shot would rearm
                    if (i_ctrl.channel_on && !o_stop) begin  // start on primary
                        state_q  <= DMACR_ST_RUN;
                        idx_q    <= `DMACR_RST_CNT;
                        addr_q   <= i_pri;
                        o_pp_sel <= 1'b0;
                    end
                end
                DMACR_ST_RUN: begin
                    if (!i_ctrl.channel_on) begin
                        state_q <= DMACR_ST_IDLE;
                    end else if (i_req && last_w) begin
                        idx_q <= `DMACR_RST_CNT;
                        if (pp_on_w) begin  // alternate buffers
                            o_pp_sel <= ~o_pp_sel;
                            addr_q   <= o_pp_sel ? i_pri : i_sec;
                        end else begin
                            addr_q <= i_pri;
                        end
                        // one-shot ends after one block per buffer in use
                        if (oneshot_w && (!pp_on_w || o_pp_sel)) begin
                            state_q <= DMACR_ST_IDLE;
                            o_stop  <= 1'b1;
                        end
                    end else if (i_req) begin
                        idx_q <= idx_q + 10'h001;
                        if (i_ctrl.addressing_select == `DMACR_AM_POSTINC) begin
                            addr_q <= addr_q + step_w;
                        end
                    end
                end
                default: begin
                    state_q <= DMACR_ST_IDLE;
                end
            endcase
        end
    end

    // issued transfer, registered so the data path sees flop outputs
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_xfer <= '0;
        end else begin
            o_xfer.valid       <= (state_q == DMACR_ST_RUN) && i_ctrl.channel_on && i_req;
            o_xfer.dir         <= i_ctrl.dir;
            o_xfer.byte_size   <= i_ctrl.byte_size;
            o_xfer.ram_addr    <= addr_q;
            o_xfer.periph_addr <= i_pad;
        end
    end

    // interrupt event: half point when selected, else whole block
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_evt <= 1'b0;
        end else begin
            o_evt <= (state_q == DMACR_ST_RUN) && i_ctrl.channel_on && i_req
                     && (i_ctrl.half ? half_w : last_w);
        end
    end

endmodule : dmacr_chan

// ===== tb/dmacr_regs_monitor.sv
/* port checker for the dma address/count register block.
   assumes it is bound onto dmacr_regs_top, one clock, async reset. */
`timescale 1ns/100ps
module dmacr_regs_monitor (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset,
    input  wire logic [7:0]             i_addr,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic [15:0]            o_rdata,
    input  wire logic [7:0]             i_req,
    input  wire dmacr_pkg::dmacr_xfer_s o_xfer [8],
    input  wire logic                   o_irq
);
    import dmacr_pkg::*;
    logic [7:0]  vld;    // issued items, all channels
    logic [15:0] pad_q;  // channel 0 peripheral address last issued
    logic        dir_q;  // channel 0 direction last issued
    logic        seen_q; // channel 0 issued since reset
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // gather valids so one check covers every channel
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            vld[k] = o_xfer[k].valid;
        end
    end
    // keep channel 0 fields, they must not drift while it runs
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pad_q  <= 16'h0000;
            dir_q  <= 1'b0;
            seen_q <= 1'b0;
        end else if (vld[0]) begin
            pad_q  <= o_xfer[0].periph_addr;
            dir_q  <= o_xfer[0].dir;
            seen_q <= 1'b1;
        end
    end
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_cnt_hi;
        $past(i_rd) && ($past(i_addr) < 8'h40) && ($past(i_addr[2:0]) == 3'h3)
            |-> o_rdata[15:10] == 6'h00;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count top bits set");
    property p_rst; $past(i_reset) |-> (o_rdata == 16'h0000) && !o_irq && (vld == 8'h00);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_req; (vld & ~$past(i_req)) == 8'h00; endproperty
    a_req: assert property (p_req) else $error("item without request");
    property p_irq_rise; $rose(o_irq) |-> $past(i_wr) || ($past(vld) != 8'h00); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt without event");
    property p_irq_fall; $fell(o_irq) |-> $past(i_wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
    property p_pad; vld[0] && seen_q |-> o_xfer[0].periph_addr == pad_q; endproperty
    a_pad: assert property (p_pad) else $error("peripheral address drifted");
    property p_dir; vld[0] && seen_q |-> o_xfer[0].dir == dir_q; endproperty
    a_dir: assert property (p_dir) else $error("direction drifted");
endmodule : dmacr_regs_monitor
bind dmacr_regs_top dmacr_regs_monitor u_mon (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .o_xfer(o_xfer), .o_irq(o_irq)
);

// ===== tb/dmacr_far_model.sv
/* far side model: takes each item, keeps the last one seen and a count of items.
   assumes at most one channel issues an item in any one cycle. */
`timescale 1ns/100ps
module dmacr_far_model (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset,
    input  wire dmacr_pkg::dmacr_xfer_s i_xfer [8],
    output dmacr_pkg::dmacr_xfer_s      o_last,
    output logic [7:0]                  o_count
);
    import dmacr_pkg::*;
    // record each item; two in one cycle would count once only
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_last  <= '0;
            o_count <= 8'h00;
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (i_xfer[k].valid) begin
                    o_last  <= i_xfer[k];
                    o_count <= o_count + 8'h01;
                end
            end
        end
    end
endmodule : dmacr_far_model

// ===== tb/dma_channel_address_count_regs_tb_top.sv
/* self-checking bench for the dma address/count register block.
   assumes the word-index map and one-cycle read latency of the block. */
`timescale 1ns/100ps
module dma_channel_address_count_regs_tb_top;
    import dmacr_pkg::*;
    logic        i_ref_clk, i_reset, i_wr, i_rd, i_sw_periph_wr, i_sw_ram_wr, o_irq;
    logic [7:0]  i_addr, i_req, count;
    logic [15:0] i_wdata, o_rdata, i_sw_periph_addr, i_sw_ram_addr;
    dmacr_xfer_s o_xfer [8];
    dmacr_xfer_s last;      // last item seen by the far side
    int          errors, comparisons, cyc;
    dmacr_regs_top dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req),
        .i_sw_periph_wr(i_sw_periph_wr), .i_sw_periph_addr(i_sw_periph_addr),
        .i_sw_ram_wr(i_sw_ram_wr), .i_sw_ram_addr(i_sw_ram_addr), .o_xfer(o_xfer),
        .o_irq(o_irq));
    dmacr_far_model far (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_xfer(o_xfer),
        .o_last(last), .o_count(count));
    // 200 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // hang guard, the whole run needs well under this
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
        // let the write settle before anyone looks at o_irq
        #1;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1;
        chk(nm, exp, o_rdata);
    endtask : rd
    // one item; sw bits: ram write, peripheral write, collision clear
    task automatic xf(input int c, input logic [2:0] sw, input logic [15:0] a);
        @(posedge i_ref_clk);
        i_req <= 8'(1 << c);
        @(posedge i_ref_clk);
        i_req            <= 8'h00;
        i_sw_ram_wr      <= sw[0];
        i_sw_ram_addr    <= a;
        i_sw_periph_wr   <= sw[1];
        i_sw_periph_addr <= a;
        i_wr             <= sw[2];
        i_addr           <= 8'h40;
        i_wdata          <= 16'hffff;
        @(posedge i_ref_clk);
        i_sw_ram_wr    <= 1'b0;
        i_sw_periph_wr <= 1'b0;
        i_wr           <= 1'b0;
        #1;
    endtask : xf
    // address and count set before the channel is switched on
    task automatic cfg(input int c, input logic [15:0] pa, pb, pr, n, ct);
        wr(8'(c * 8), pa);
        wr(8'(c * 8 + 1), pb);
        wr(8'(c * 8 + 2), pr);
        wr(8'(c * 8 + 3), n);
        wr(8'(c * 8 + 4), ct);
    endtask : cfg
    initial begin
        {errors, comparisons, cyc} = '0;
        {i_reset, i_wr, i_rd, i_sw_periph_wr, i_sw_ram_wr} = 5'b10000;
        {i_addr, i_req, i_wdata, i_sw_periph_addr, i_sw_ram_addr} = '0;
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        for (int k = 0; k < 36; k++) begin
            rd((k < 32) ? 8'((k / 4) * 8 + k % 4) : 8'(k + 32), 16'h0000, "reset");
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'(c * 8), 16'ha000 | 16'(c));
            wr(8'(c * 8 + 1), 16'hb000 | 16'(c));
            wr(8'(c * 8 + 2), 16'hc000 | 16'(c));
            wr(8'(c * 8 + 3), 16'hffff);
            rd(8'(c * 8), 16'ha000 | 16'(c), "primary start");
            rd(8'(c * 8 + 1), 16'hb000 | 16'(c), "secondary start");
            rd(8'(c * 8 + 2), 16'hc000 | 16'(c), "periph addr");
            rd(8'(c * 8 + 3), 16'h03ff, "count");
        end
        wr(8'h50, 16'h1234);
        rd(8'h50, 16'h0000, "unmapped");
        wr(8'h42, 16'h0001);
        cfg(0, 16'h0100, 16'h0200, 16'h0030, 16'h0002, 16'h8002);
        xf(0, 3'b000, 16'h0000);
        chk("ram addr", 16'h0100, last.ram_addr);
        chk("periph addr", 16'h0030, last.periph_addr);
        chk("dir", 16'h0000, {15'h0000, last.dir});
        xf(0, 3'b001, 16'h0102);
        chk("ram addr", 16'h0102, last.ram_addr);
        chk("irq mid block", 16'h0000, {15'h0000, o_irq});
        xf(0, 3'b000, 16'h0000);
        chk("ram addr", 16'h0104, last.ram_addr);
        chk("irq block end", 16'h0001, {15'h0000, o_irq});
        rd(8'h43, 16'h0001, "buffer select");
        xf(0, 3'b000, 16'h0000);
        chk("ram addr", 16'h0200, last.ram_addr);
        rd(8'h40, 16'h0001, "ram collision");
        wr(8'h42, 16'h0000);
        chk("irq masked", 16'h0000, {15'h0000, o_irq});
        wr(8'h42, 16'h0001);
        chk("irq unmasked", 16'h0001, {15'h0000, o_irq});
        wr(8'h41, 16'h0001);
        chk("irq cleared", 16'h0000, {15'h0000, o_irq});
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000, "collision cleared");
        // two items per block, so the fixed mode is seen inside a block
        cfg(1, 16'h0300, 16'h0000, 16'h0040, 16'h0001, 16'ha010);
        xf(1, 3'b010, 16'h0040);
        chk("dir", 16'h0001, {15'h0000, last.dir});
        xf(1, 3'b000, 16'h0000);
        chk("fixed addr", 16'h0300, last.ram_addr);
        rd(8'h40, 16'h0200, "periph collision");
        xf(1, 3'b110, 16'h0040);
        rd(8'h40, 16'h0200, "collision in clear");
        rd(8'h41, 16'h0002, "block event");
        // half option: four items, event after the second only
        cfg(3, 16'h0500, 16'h0000, 16'h0060, 16'h0003, 16'h9000);
        xf(3, 3'b000, 16'h0000);
        rd(8'h41, 16'h0002, "no half event yet");
        xf(3, 3'b000, 16'h0000);
        rd(8'h41, 16'h000a, "half block event");
        cfg(2, 16'h0400, 16'h0000, 16'h0050, 16'h0001, 16'hc001);
        xf(2, 3'b000, 16'h0000);
        xf(2, 3'b000, 16'h0000);
        chk("byte step", 16'h0401, last.ram_addr);
        rd(8'h14, 16'h4001, "one-shot stopped");
        xf(2, 3'b000, 16'h0000);
        chk("items", 16'h000b, {8'h00, count});
        summarize();
    end
endmodule : dma_channel_address_count_regs_tb_top
